// >>> acl_defines.svh
// Function
// RQ1: Processing entry holds 4-bit pointer to action rule 0..15, taken when selected matches true.
// RQ2: Processing entry 16-bit mask selects matching rules; selected results are ANDed.
// RQ3: One action per packet; lowest matching pointer value wins.
// RQ4: Entries sharing one action pointer combine by OR.
// RQ5: Layer mode 00 off, 01 layer 2 or count, 10 IPv4, 11 layer 4.
// RQ6: Layer 2 option 00 count, 01 MAC, 10 EtherType, 11 both.
// RQ7: Layer 3 option 01 one masked address, 10 both unmasked, 00/11 reserved.
// RQ8: Layer 4 option 00 protocol, 01 TCP port, 10 UDP port, 11 TCP sequence.
// RQ9: Source select 0 compares destination field, 1 source field.
// RQ10: Polarity 0 makes mismatch true, 1 makes equality true.
// RQ11: Layer 2 rule stores 48-bit MAC address and 16-bit EtherType.
// RQ12: Count mode reads action priority/remark/map fields as one 11-bit count.
// RQ13: Action time-unit bit picks microsecond (0) or millisecond (1) tick.
// RQ14: Algorithm 0: counter loaded, decrements per tick, event on expiry.
// RQ15: Algorithm 1: counter increments per matched packet, event at terminal count, resets.
// RQ16: Counting matching rule uses action rule at same index for its count.
// RQ17: Sixteen ordered entries, entry zero highest; every matching rule evaluated per packet. Code ranks hits by action pointer value, not by entry index.
// RQ18: Table applies to frames received on its own port.
// RQ19: Disabled or reserved-option matching rule evaluates false.
// RQ20: Timed count mode reloads counter on each qualifying packet.
`ifndef ACL_DEFINES_SVH
`define ACL_DEFINES_SVH

`define ACL_NUM 16
`define ACL_MODE_OFF 2'h0
`define ACL_MODE_L2 2'h1
`define ACL_MODE_L3 2'h2
`define ACL_MODE_L4 2'h3
`define ACL_OPT_0 2'h0
`define ACL_OPT_1 2'h1
`define ACL_OPT_2 2'h2
`define ACL_OPT_3 2'h3
`define ACL_CNT_RST 11'h000
`define ACL_CLK_NS 50
`define ACL_US_NS 1000
`define ACL_MS_NS 1000000
`define ACL_US_CYCLES (`ACL_US_NS / `ACL_CLK_NS)
`define ACL_MS_CYCLES (`ACL_MS_NS / `ACL_CLK_NS)

`endif

// >>> acl_pkg.sv
package acl_pkg;

  typedef enum logic [1:0] {
    CFG_PROC,
    CFG_MATCH,
    CFG_ACTION
  } cfg_sel_t;

  typedef struct packed {
    logic [3:0] action_pointer;
    logic [15:0] match_select_mask;
  } proc_entry_t;

  typedef struct packed {
    logic [1:0] match_layer_mode;
    logic [1:0] match_option;
    logic src_sel;
    logic match_polarity;
    logic [47:0] mac_addr;
    logic [15:0] ether_type;
    logic [31:0] ip_addr;
    logic [31:0] ip_mask;
    logic [7:0] ip_proto;
    logic [15:0] port_max;
    logic [15:0] port_min;
  } match_rule_t;

  typedef struct packed {
    logic [1:0] priority_mode_field;
    logic [2:0] priority_field;
    logic remark_enable_field;
    logic [2:0] remark_priority_field;
    logic [1:0] map_mode_field;
    logic count_time_unit;
    logic count_algorithm;
    logic [2:0] forward_map;
  } action_rule_t;

  typedef struct packed {
    logic [47:0] dst_mac;
    logic [47:0] src_mac;
    logic [15:0] ether_type;
    logic [31:0] src_ip;
    logic [31:0] dst_ip;
    logic [7:0] ip_proto;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [31:0] tcp_seq;
    logic is_ipv4;
    logic is_tcp;
    logic is_udp;
  } pkt_hdr_t;

endpackage

// >>> acl_rule_evaluator.sv
`timescale 1ns/100ps
`include "acl_defines.svh"

module acl_rule_evaluator #(
  parameter int MS_TICK_CYCLES = `ACL_MS_CYCLES
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CFG_WR_I,
  input wire acl_pkg::cfg_sel_t CFG_SEL_I,
  input wire logic [3:0] CFG_IDX_I,
  input wire acl_pkg::proc_entry_t CFG_PROC_I,
  input wire acl_pkg::match_rule_t CFG_MATCH_I,
  input wire acl_pkg::action_rule_t CFG_ACTION_I,
  input wire logic PKT_VALID_I,
  input wire acl_pkg::pkt_hdr_t PKT_HDR_I,
  output logic ACT_VALID_O,
  output logic ACT_HIT_O,
  output logic [3:0] ACT_INDEX_O,
  output acl_pkg::action_rule_t ACT_RULE_O,
  output logic [15:0] MATCH_VEC_O,
  output logic [15:0] COUNT_EVENT_O
);

  localparam int US_W = $clog2(`ACL_US_CYCLES);
  localparam int MS_W = $clog2(MS_TICK_CYCLES);

  // ==========================================================
  // Tables
  acl_pkg::proc_entry_t proc_q [`ACL_NUM];
  acl_pkg::proc_entry_t proc_d [`ACL_NUM];
  acl_pkg::match_rule_t rule_q [`ACL_NUM];
  acl_pkg::match_rule_t rule_d [`ACL_NUM];
  acl_pkg::action_rule_t act_q [`ACL_NUM];
  acl_pkg::action_rule_t act_d [`ACL_NUM];

  always_comb begin
    proc_d = proc_q;
    rule_d = rule_q;
    act_d = act_q;
    if (CFG_WR_I) begin
      case (CFG_SEL_I)
        acl_pkg::CFG_PROC: proc_d[CFG_IDX_I] = CFG_PROC_I;
        acl_pkg::CFG_MATCH: rule_d[CFG_IDX_I] = CFG_MATCH_I;
        acl_pkg::CFG_ACTION: act_d[CFG_IDX_I] = CFG_ACTION_I;
        default: proc_d = proc_q;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < `ACL_NUM; i++) begin
        proc_q[i] <= '0;
        rule_q[i] <= '0;
        act_q[i] <= '0;
      end
    end else begin
      proc_q <= proc_d;
      rule_q <= rule_d;
      act_q <= act_d;
    end
  end

  // ==========================================================
  // Header capture
  acl_pkg::pkt_hdr_t hdr_q;
  acl_pkg::pkt_hdr_t hdr_d;
  logic hv_q;
  logic hv_d;

  always_comb begin
    hv_d = PKT_VALID_I;
    hdr_d = PKT_VALID_I ? PKT_HDR_I : hdr_q;
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      hv_q <= 1'b0;
      hdr_q <= '0;
    end else begin
      hv_q <= hv_d;
      hdr_q <= hdr_d;
    end
  end

  // ==========================================================
  // Matching rules
  // Returns {usable, equal}
  function automatic logic [1:0] rule_cmp(input acl_pkg::match_rule_t r, input acl_pkg::pkt_hdr_t h);
    logic [47:0] mac;
    logic [31:0] ip;
    logic [15:0] port;
    logic ok;
    logic eq;
    mac = r.src_sel ? h.src_mac : h.dst_mac; // RQ9
    ip = r.src_sel ? h.src_ip : h.dst_ip; // RQ9
    port = r.src_sel ? h.src_port : h.dst_port; // RQ9
    ok = 1'b0;
    eq = 1'b0;
    case (r.match_layer_mode) // RQ5
      `ACL_MODE_L2: begin
        ok = (r.match_option != `ACL_OPT_0); // RQ6
        case (r.match_option)
          `ACL_OPT_1: eq = (mac == r.mac_addr); // RQ11
          `ACL_OPT_2: eq = (h.ether_type == r.ether_type);
          default: eq = (mac == r.mac_addr) && (h.ether_type == r.ether_type);
        endcase
      end
      `ACL_MODE_L3: begin
        ok = h.is_ipv4 && (r.match_option == `ACL_OPT_1 || r.match_option == `ACL_OPT_2); // RQ7 RQ19
        if (r.match_option == `ACL_OPT_1) begin
          eq = ((ip ^ r.ip_addr) & ~r.ip_mask) == 32'h0000_0000;
        end else begin
          eq = (h.src_ip == r.ip_addr) && (h.dst_ip == r.ip_mask);
        end
      end
      `ACL_MODE_L4: begin
        case (r.match_option) // RQ8
          `ACL_OPT_0: begin
            ok = h.is_ipv4;
            eq = (h.ip_proto == r.ip_proto);
          end
          `ACL_OPT_1: begin
            ok = h.is_tcp;
            eq = (port == r.port_min) || (port == r.port_max);
          end
          `ACL_OPT_2: begin
            ok = h.is_udp;
            eq = (port == r.port_min) || (port == r.port_max);
          end
          default: begin
            ok = h.is_tcp;
            eq = (h.tcp_seq == {r.port_max, r.port_min});
          end
        endcase
      end
      default: ok = 1'b0; // RQ19
    endcase
    return {ok, eq};
  endfunction

  logic [15:0] match_res;
  logic [15:0] cnt_mode;
  logic [15:0] cnt_hit;
  logic [15:0] off_v;

  always_comb begin
    logic [1:0] c;
    logic l2eq;
    c = 2'h0;
    l2eq = 1'b0;
    for (int i = 0; i < `ACL_NUM; i++) begin // RQ17
      c = rule_cmp(rule_q[i], hdr_q);
      match_res[i] = c[1] && (rule_q[i].match_polarity ? c[0] : !c[0]); // RQ10
      off_v[i] = (rule_q[i].match_layer_mode == `ACL_MODE_OFF) || ((rule_q[i].match_layer_mode == `ACL_MODE_L3)
                 && (rule_q[i].match_option == `ACL_OPT_0 || rule_q[i].match_option == `ACL_OPT_3));
      cnt_mode[i] = (rule_q[i].match_layer_mode == `ACL_MODE_L2) && (rule_q[i].match_option == `ACL_OPT_0);
      l2eq = (hdr_q.dst_mac == rule_q[i].mac_addr) && (hdr_q.ether_type == rule_q[i].ether_type);
      if (rule_q[i].src_sel) begin
        l2eq = (hdr_q.src_mac == rule_q[i].mac_addr) && (hdr_q.ether_type == rule_q[i].ether_type);
      end
      cnt_hit[i] = hv_q && cnt_mode[i] && (rule_q[i].match_polarity ? l2eq : !l2eq);
    end
  end

  // ==========================================================
  // Processing entries and priority
  logic [15:0] entry_match;
  logic [15:0] hit_v;
  logic [3:0] pick;

  always_comb begin
    hit_v = '0;
    pick = 4'h0;
    for (int e = 0; e < `ACL_NUM; e++) begin
      entry_match[e] = (proc_q[e].match_select_mask != 16'h0000)
                       && ((proc_q[e].match_select_mask & ~match_res) == 16'h0000); // RQ2
      if (entry_match[e]) begin
        hit_v[proc_q[e].action_pointer] = 1'b1; // RQ1 RQ4
      end
    end
    for (int a = `ACL_NUM - 1; a >= 0; a--) begin
      if (hit_v[a]) begin
        pick = 4'(a); // RQ3
      end
    end
  end

  // ==========================================================
  // Result outputs
  logic act_valid_d;
  logic act_hit_d;
  logic [3:0] act_index_d;
  acl_pkg::action_rule_t act_rule_d;
  logic [15:0] match_vec_d;

  always_comb begin
    act_valid_d = hv_q; // RQ18
    act_hit_d = hv_q && (hit_v != 16'h0000);
    act_index_d = hv_q ? pick : ACT_INDEX_O;
    act_rule_d = hv_q ? act_q[pick] : ACT_RULE_O;
    match_vec_d = hv_q ? match_res : MATCH_VEC_O;
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ACT_VALID_O <= 1'b0;
      ACT_HIT_O <= 1'b0;
      ACT_INDEX_O <= 4'h0;
      ACT_RULE_O <= '0;
      MATCH_VEC_O <= 16'h0000;
    end else begin
      ACT_VALID_O <= act_valid_d;
      ACT_HIT_O <= act_hit_d;
      ACT_INDEX_O <= act_index_d;
      ACT_RULE_O <= act_rule_d;
      MATCH_VEC_O <= match_vec_d;
    end
  end

  // ==========================================================
  // Time base
  logic [US_W-1:0] us_q;
  logic [US_W-1:0] us_d;
  logic [MS_W-1:0] ms_q;
  logic [MS_W-1:0] ms_d;
  logic us_tick;
  logic ms_tick;

  always_comb begin
    us_tick = (us_q == US_W'(`ACL_US_CYCLES - 1));
    ms_tick = (ms_q == MS_W'(MS_TICK_CYCLES - 1));
    us_d = us_tick ? '0 : us_q + US_W'(1);
    ms_d = ms_tick ? '0 : ms_q + MS_W'(1);
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      us_q <= '0;
      ms_q <= '0;
    end else begin
      us_q <= us_d;
      ms_q <= ms_d;
    end
  end

  // ==========================================================
  // Count mode
  logic [10:0] cnt_q [`ACL_NUM];
  logic [10:0] cnt_d [`ACL_NUM];
  logic [15:0] arm_q;
  logic [15:0] arm_d;
  logic [15:0] evt_d;

  always_comb begin
    logic [10:0] cval;
    logic tick;
    cval = 11'h000;
    tick = 1'b0;
    cnt_d = cnt_q;
    arm_d = arm_q;
    evt_d = 16'h0000;
    for (int i = 0; i < `ACL_NUM; i++) begin
      cval = {act_q[i].priority_mode_field, act_q[i].priority_field, act_q[i].remark_enable_field,
              act_q[i].remark_priority_field, act_q[i].map_mode_field}; // RQ12 RQ16
      tick = act_q[i].count_time_unit ? ms_tick : us_tick; // RQ13
      if (!cnt_mode[i]) begin
        cnt_d[i] = `ACL_CNT_RST;
        arm_d[i] = 1'b0;
      end else if (!act_q[i].count_algorithm) begin
        if (cnt_hit[i]) begin
          cnt_d[i] = cval; // RQ20
          arm_d[i] = 1'b1;
        end else if (arm_q[i] && tick) begin
          if (cnt_q[i] <= 11'h001) begin
            evt_d[i] = 1'b1; // RQ14
            arm_d[i] = 1'b0;
            cnt_d[i] = `ACL_CNT_RST;
          end else begin
            cnt_d[i] = cnt_q[i] - 11'h001; // RQ14
          end
        end
      end else if (cnt_hit[i]) begin
        if ((cnt_q[i] + 11'h001) == cval) begin
          evt_d[i] = 1'b1; // RQ15
          cnt_d[i] = `ACL_CNT_RST;
        end else begin
          cnt_d[i] = cnt_q[i] + 11'h001;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < `ACL_NUM; i++) begin
        cnt_q[i] <= `ACL_CNT_RST;
      end
      arm_q <= 16'h0000;
      COUNT_EVENT_O <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
      arm_q <= arm_d;
      COUNT_EVENT_O <= evt_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  logic [10:0] cval4;
  assign cval4 = {act_q[4].priority_mode_field, act_q[4].priority_field, act_q[4].remark_enable_field,
                  act_q[4].remark_priority_field, act_q[4].map_mode_field};

  sequence s_pkt_in;
    PKT_VALID_I;
  endsequence

  sequence s_timed_load4;
    cnt_hit[4] && !act_q[4].count_algorithm;
  endsequence

  chk_result_latency: assert property (s_pkt_in |-> ##2 ACT_VALID_O) // RQ17
    else $error("result not two cycles after packet");
  chk_off_false: assert property ((match_res & off_v) == 16'h0000) // RQ19
    else $error("disabled rule reported true");
  chk_lowest_action: assert property (ACT_HIT_O |-> (($past(hit_v) >> ACT_INDEX_O) & 16'h0001) == 16'h0001 // RQ3
      && (($past(hit_v) & ((16'h0001 << ACT_INDEX_O) - 16'h0001)) == 16'h0000))
    else $error("action not lowest hit");
  chk_or_combine: assert property ((hit_v != 16'h0000) == (entry_match != 16'h0000)) // RQ4
    else $error("action hits disagree with entries");
  chk_and_mask: assert property (entry_match[0] |-> (proc_q[0].match_select_mask & ~match_res) == 16'h0000) // RQ2
    else $error("entry matched with false selected rule");
  chk_hit_rule: assert property (ACT_HIT_O && !$past(CFG_WR_I) |-> ACT_RULE_O == act_q[ACT_INDEX_O]) // RQ1
    else $error("action rule contents mismatch");
  chk_timed_reload: assert property (s_timed_load4 |=> cnt_q[4] == $past(cval4) && arm_q[4]) // RQ20
    else $error("timed counter not reloaded");
  chk_expire_disarm: assert property (COUNT_EVENT_O[4] && !act_q[4].count_algorithm |-> !arm_q[4]) // RQ14
    else $error("timer still armed after expiry");
  chk_count_wrap: assert property (COUNT_EVENT_O[3] && act_q[3].count_algorithm |-> cnt_q[3] == 11'h000) // RQ15
    else $error("event counter not reset");
  chk_us_tick: assert property (us_tick |=> !us_tick ##18 !us_tick ##1 us_tick) // RQ13
    else $error("microsecond tick spacing wrong");

endmodule

// >>> pkt_parser_model.sv
`timescale 1ns/100ps
// ==========================================
// Ingress parser model: hands one header per request
module pkt_parser_model (
  input wire logic clk_i,
  input wire logic send_i,
  input wire acl_pkg::pkt_hdr_t hdr_i,
  output logic valid_o,
  output acl_pkg::pkt_hdr_t hdr_o
);
  acl_pkg::pkt_hdr_t last_q = '0;
  always @(posedge clk_i) begin
    if (send_i) begin
      last_q <= hdr_i;
    end
  end
  // Header not held outside its valid cycle
  assign valid_o = send_i;
  assign hdr_o = send_i ? hdr_i : ~last_q;
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
// ==========================================
// Bench top
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic send = 1'b0;
  acl_pkg::cfg_sel_t sel = acl_pkg::CFG_PROC;
  logic [3:0] idx = 4'h0;
  acl_pkg::proc_entry_t cp = '0;
  acl_pkg::match_rule_t cm = '0;
  acl_pkg::action_rule_t ca = '0;
  acl_pkg::pkt_hdr_t hdr = '0;
  acl_pkg::pkt_hdr_t phdr;
  acl_pkg::action_rule_t act_rule;
  logic pvalid, act_valid, act_hit;
  logic [3:0] act_idx;
  logic [15:0] mvec, cev;
  int err_total = 0;
  int n_tests = 0;
  int seed = 16936;
  int ev4 = 0;
  localparam logic [47:0] MAC_A = 48'h0200000000a1;
  localparam logic [47:0] MAC_B = 48'h0200000000b2;
  localparam logic [47:0] MAC_C = 48'h0200000000c3;
  localparam logic [47:0] MAC_D = 48'h0200000000d4;
  localparam logic [15:0] ET_E = 16'h88b5;
  localparam logic [31:0] IP_S = 32'h0a00_0005;
  localparam logic [31:0] IP_D = 32'h0a00_0009;
  localparam logic [31:0] SEQ = 32'h01bb_0050;

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (cev[4] === 1'b1) begin
      ev4 <= ev4 + 1;
    end
  end

  acl_rule_evaluator #(.MS_TICK_CYCLES(50)) acl_rule_evaluator_inst (
    .REF_CLK_I(clk), .RST_I(rst), .CFG_WR_I(wr), .CFG_SEL_I(sel), .CFG_IDX_I(idx),
    .CFG_PROC_I(cp), .CFG_MATCH_I(cm), .CFG_ACTION_I(ca), .PKT_VALID_I(pvalid),
    .PKT_HDR_I(phdr), .ACT_VALID_O(act_valid), .ACT_HIT_O(act_hit), .ACT_INDEX_O(act_idx),
    .ACT_RULE_O(act_rule), .MATCH_VEC_O(mvec), .COUNT_EVENT_O(cev));
  pkt_parser_model pkt_parser_model_inst (
    .clk_i(clk), .send_i(send), .hdr_i(hdr), .valid_o(pvalid), .hdr_o(phdr));

  // ==========================================
  // Helpers
  task close_out;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  function acl_pkg::match_rule_t l2(logic [1:0] md, logic [1:0] opt, logic src, logic pol,
                                    logic [47:0] mac, logic [15:0] et);
    l2 = '0;
    l2.match_layer_mode = md;
    l2.match_option = opt;
    l2.src_sel = src;
    l2.match_polarity = pol;
    l2.mac_addr = mac;
    l2.ether_type = et;
  endfunction

  function acl_pkg::proc_entry_t pe(logic [3:0] ptr, logic [15:0] mask);
    pe.action_pointer = ptr;
    pe.match_select_mask = mask;
  endfunction

  function int winner(logic m0, logic m1, logic m2);
    if ((m0 && m1) || m2) return 2;
    if (m0) return 6;
    if (m1) return 9;
    return -1;
  endfunction

  task cfg(acl_pkg::cfg_sel_t s, int i, acl_pkg::proc_entry_t p, acl_pkg::match_rule_t m,
           acl_pkg::action_rule_t a);
    @(posedge clk);
    wr <= 1'b1;
    sel <= s;
    idx <= i[3:0];
    cp <= p;
    cm <= m;
    ca <= a;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task pkth(input acl_pkg::pkt_hdr_t h);
    @(posedge clk);
    hdr <= h;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    #1;
    check(act_valid === 1'b1, "no result pulse");
  endtask

  task pkt(input logic [47:0] d, input logic [47:0] s, input logic [15:0] et);
    acl_pkg::pkt_hdr_t h;
    h = '0;
    h.dst_mac = d;
    h.src_mac = s;
    h.ether_type = et;
    pkth(h);
  endtask

  // ==========================================
  // Main sequence
  initial begin : main
    acl_pkg::action_rule_t a;
    logic [47:0] d, s;
    logic [15:0] et;
    logic [2:0] r;
    int w;
    acl_pkg::match_rule_t m;
    acl_pkg::pkt_hdr_t h;
    logic [31:0] v;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(act_valid === 1'b0 && mvec === 16'h0000, "reset state");
    cfg(acl_pkg::CFG_MATCH, 0, '0, l2(2'h1, 2'h1, 1'b0, 1'b1, MAC_A, 16'h0000), '0);
    cfg(acl_pkg::CFG_MATCH, 1, '0, l2(2'h1, 2'h2, 1'b0, 1'b1, 48'h0, ET_E), '0);
    cfg(acl_pkg::CFG_MATCH, 2, '0, l2(2'h1, 2'h1, 1'b1, 1'b1, MAC_B, 16'h0000), '0);
    cfg(acl_pkg::CFG_MATCH, 5, '0, l2(2'h1, 2'h1, 1'b1, 1'b0, MAC_B, 16'h0000), '0);
    cfg(acl_pkg::CFG_MATCH, 7, '0, l2(2'h0, 2'h1, 1'b0, 1'b1, MAC_A, 16'h0000), '0);
    cfg(acl_pkg::CFG_MATCH, 8, '0, l2(2'h2, 2'h0, 1'b0, 1'b1, MAC_A, 16'h0000), '0);
    cfg(acl_pkg::CFG_PROC, 0, pe(4'h6, 16'h0001), '0, '0);
    cfg(acl_pkg::CFG_PROC, 1, pe(4'h2, 16'h0003), '0, '0);
    cfg(acl_pkg::CFG_PROC, 2, pe(4'h2, 16'h0004), '0, '0);
    cfg(acl_pkg::CFG_PROC, 3, pe(4'h9, 16'h0022), '0, '0);
    cfg(acl_pkg::CFG_PROC, 5, pe(4'h0, 16'h0080), '0, '0);
    cfg(acl_pkg::CFG_PROC, 6, pe(4'h1, 16'h0100), '0, '0);
    for (int i = 0; i < 16; i++) begin
      a = '0;
      a.forward_map = i[2:0];
      cfg(acl_pkg::CFG_ACTION, i, '0, '0, a);
    end
    for (int i = 0; i < 48; i++) begin
      r = (i < 8) ? i[2:0] : 3'($random(seed));
      d = r[0] ? MAC_A : 48'({$random(seed), $random(seed)});
      s = r[1] ? MAC_B : 48'({$random(seed), $random(seed)});
      et = r[2] ? ET_E : 16'($random(seed));
      pkt(d, s, et);
      w = winner(d == MAC_A, et == ET_E, s == MAC_B);
      check(act_hit === (w >= 0), "hit flag");
      if (w >= 0) begin
        check(act_idx === w[3:0] && act_rule.forward_map === w[2:0], "winner");
      end
      check(mvec[2:0] === {s == MAC_B, et == ET_E, d == MAC_A}, "l2 compare");
      check(mvec[5] === (s != MAC_B), "inverted compare");
      check(mvec[8:7] === 2'b00, "disabled rule");
    end
    a = '0;
    a.map_mode_field = 2'h3;
    a.count_algorithm = 1'b1;
    cfg(acl_pkg::CFG_ACTION, 3, '0, '0, a);
    cfg(acl_pkg::CFG_MATCH, 3, '0, l2(2'h1, 2'h0, 1'b0, 1'b1, MAC_C, ET_E), '0);
    for (int k = 1; k <= 3; k++) begin
      pkt(MAC_C, 48'h0, ET_E);
      check(cev[3] === (k == 3), "packet count event");
      check(mvec[3] === 1'b0, "count rule result");
    end
    a = '0;
    a.map_mode_field = 2'h2;
    cfg(acl_pkg::CFG_ACTION, 4, '0, '0, a);
    cfg(acl_pkg::CFG_MATCH, 4, '0, l2(2'h1, 2'h0, 1'b0, 1'b1, MAC_D, ET_E), '0);
    for (int k = 0; k < 4; k++) begin
      pkt(MAC_D, 48'h0, ET_E);
      repeat (12) @(posedge clk);
    end
    check(ev4 === 0, "early watchdog");
    repeat (48) @(posedge clk);
    check(ev4 === 1, "watchdog expiry");
    a.count_time_unit = 1'b1;
    cfg(acl_pkg::CFG_ACTION, 4, '0, '0, a);
    pkt(MAC_D, 48'h0, ET_E);
    repeat (45) @(posedge clk);
    check(ev4 === 1, "millisecond unit early");
    repeat (70) @(posedge clk);
    check(ev4 === 2, "millisecond expiry");
    m = l2(2'h2, 2'h1, 1'b1, 1'b1, 48'h0, 16'h0000);
    m.ip_addr = IP_S;
    m.ip_mask = 32'h0000_00ff;
    cfg(acl_pkg::CFG_MATCH, 9, '0, m, '0);
    m.match_option = 2'h2;
    m.ip_mask = IP_D;
    cfg(acl_pkg::CFG_MATCH, 10, '0, m, '0);
    m = l2(2'h3, 2'h1, 1'b0, 1'b1, 48'h0, 16'h0000);
    m.port_min = 16'h0050;
    m.port_max = 16'h01bb;
    m.ip_proto = 8'h11;
    cfg(acl_pkg::CFG_MATCH, 11, '0, m, '0);
    m.match_option = 2'h2;
    m.src_sel = 1'b1;
    cfg(acl_pkg::CFG_MATCH, 15, '0, m, '0);
    m.match_option = 2'h3;
    cfg(acl_pkg::CFG_MATCH, 14, '0, m, '0);
    m.match_option = 2'h0;
    m.match_polarity = 1'b0;
    cfg(acl_pkg::CFG_MATCH, 12, '0, m, '0);
    cfg(acl_pkg::CFG_MATCH, 13, '0, l2(2'h1, 2'h3, 1'b0, 1'b1, MAC_A, ET_E), '0);
    for (int i = 0; i < 32; i++) begin
      v = 32'($random(seed));
      h = '0;
      h.dst_mac = v[0] ? MAC_A : MAC_B;
      h.ether_type = v[1] ? ET_E : 16'($random(seed));
      h.src_ip = v[2] ? IP_S : {v[3] ? 24'h0a0000 : 24'($random(seed)), 8'($random(seed))};
      h.dst_ip = v[4] ? IP_D : 32'($random(seed));
      h.ip_proto = v[5] ? 8'h11 : 8'($random(seed));
      h.dst_port = v[6] ? (v[7] ? 16'h0050 : 16'h01bb) : 16'($random(seed));
      h.src_port = v[8] ? 16'h01bb : 16'($random(seed));
      h.tcp_seq = v[9] ? SEQ : 32'($random(seed));
      h.is_ipv4 = v[10] | v[11];
      h.is_tcp = v[11] & ~v[12];
      h.is_udp = v[11] & v[12];
      pkth(h);
      check(mvec[9] === (h.is_ipv4 && h.src_ip[31:8] == 24'h0a0000), "masked address");
      check(mvec[10] === (h.is_ipv4 && h.src_ip == IP_S && h.dst_ip == IP_D), "address pair");
      check(mvec[11] === (h.is_tcp && (h.dst_port == 16'h0050 || h.dst_port == 16'h01bb)), "tcp port");
      check(mvec[12] === (h.is_ipv4 && h.ip_proto != 8'h11), "protocol");
      check(mvec[13] === (h.dst_mac == MAC_A && h.ether_type == ET_E), "mac and type");
      check(mvec[14] === (h.is_tcp && h.tcp_seq == SEQ), "sequence");
      check(mvec[15] === (h.is_udp && (h.src_port == 16'h0050 || h.src_port == 16'h01bb)), "udp port");
    end
    close_out();
  end

  initial begin : watchdog
    #100000;
    err_total++;
    $display("BAD %0t watchdog", $time);
    close_out();
  end
endmodule
